// file: pkg/wdcfg_regs.svh
// Register indices, field positions and reset values of the timer configuration bank
`ifndef WDCFG_REGS_SVH
`define WDCFG_REGS_SVH
`define WDCFG_IDX_ACTIVATE    8'h30
`define WDCFG_IDX_BASE_HIGH   8'h60
`define WDCFG_IDX_BASE_LOW    8'h61
`define WDCFG_IDX_IRQ_SELECT  8'h70
`define WDCFG_IDX_IRQ_KIND    8'h71
`define WDCFG_IDX_DMA_A       8'h74
`define WDCFG_IDX_DMA_B       8'h75
`define WDCFG_IDX_SETUP       8'hF0
`define WDCFG_IDX_EVT_STATUS  8'hF8
`define WDCFG_IDX_EVT_CLEAR   8'hF9
`define WDCFG_IDX_EVT_ENABLE  8'hFA
`define WDCFG_RST_ACTIVATE    8'h00
`define WDCFG_RST_BASE        8'h00
`define WDCFG_RST_IRQ_SELECT  8'h00
`define WDCFG_RST_IRQ_KIND    8'h03
`define WDCFG_VAL_NO_DMA      8'h04
`define WDCFG_RST_SETUP       8'h02
`define WDCFG_BASE_LOW_MASK   8'hFC
`define WDCFG_IRQ_KIND_WMASK  8'h02
`define WDCFG_SETUP_WMASK     8'h0F
`define WDCFG_BIT_ACT_ENABLE  0
`define WDCFG_BIT_HIZ_CTRL    0
`define WDCFG_BIT_POWER_MODE  1
`define WDCFG_BIT_PULLUP      2
`define WDCFG_BIT_PUSH_PULL   3
`define WDCFG_EVT_EXPIRY      0
`define WDCFG_EVT_LOW_POWER   1
`define WDCFG_EVT_BLOCKED     2
`endif

// file: pkg/wdcfg_pkg.sv
// Types shared by the timer configuration bank
package wdcfg_pkg;
    typedef logic [7:0] wdcfg_byte_t;
    typedef struct packed {
        logic timer_clk_en;
        logic pullup_en;
        logic out_value;
        logic out_enable;
    } wdcfg_pin_s;
    typedef enum logic [1:0] {
        WDCFG_OFF    = 2'b00,
        WDCFG_LOWPWR = 2'b01,
        WDCFG_RUN    = 2'b10
    } wdcfg_mode_e;
endpackage

// file: verilog/wdcfg_bank.sv
// Configuration register bank and timeout pin control of the expiry timer
`timescale 1ns/1ns
`default_nettype none
`include "wdcfg_regs.svh"

module wdcfg_bank (
    input  wire logic        MCLK_I,
    input  wire logic        RSTN_I,
    input  wire logic [7:0]  ADDR_I,
    input  wire logic [7:0]  WDATA_I,
    input  wire logic        WR_I,
    input  wire logic        RD_I,
    output logic      [7:0]  RDATA_O,
    input  wire logic        TIMEOUT_N_I,
    input  wire logic        RT_ACCESS_I,
    output logic             RT_ACCESS_OK_O,
    output logic             TIMER_CLK_EN_O,
    output logic             TIMEOUT_OUTPUT_N_O,
    output logic             TIMEOUT_OUTPUT_N_OE_O,
    output logic             TIMEOUT_PULLUP_O,
    output logic      [7:0]  IRQ_SELECT_O,
    output logic             IRQ_O
);
    wdcfg_pkg::wdcfg_byte_t activate;
    wdcfg_pkg::wdcfg_byte_t base_high;
    wdcfg_pkg::wdcfg_byte_t base_low;
    wdcfg_pkg::wdcfg_byte_t irq_select;
    wdcfg_pkg::wdcfg_byte_t irq_kind;
    wdcfg_pkg::wdcfg_byte_t setup;
    logic [2:0]             evt_status;
    logic [2:0]             evt_enable;
    logic                   to_meta;
    logic                   to_sync;
    logic                   to_prev;
    logic                   blk_meta;
    logic                   blk_sync;
    wdcfg_pkg::wdcfg_mode_e mode;
    wdcfg_pkg::wdcfg_pin_s  next_pin;
    wdcfg_pkg::wdcfg_pin_s  pin;
    logic                   active;
    logic                   wr_hit_act;
    logic                   wr_hit_setup;
    logic [2:0]             evt_set;

    assign active = activate[`WDCFG_BIT_ACT_ENABLE];

    // Plain config writes
    always_ff @(posedge MCLK_I) begin
        if (!RSTN_I) begin
            activate   <= `WDCFG_RST_ACTIVATE;
            base_high  <= `WDCFG_RST_BASE;
            base_low   <= `WDCFG_RST_BASE;
            irq_select <= `WDCFG_RST_IRQ_SELECT;
            irq_kind   <= `WDCFG_RST_IRQ_KIND;
        end else if (WR_I) begin
            case (ADDR_I)
                `WDCFG_IDX_ACTIVATE: begin
                    activate <= WDATA_I;
                end
                `WDCFG_IDX_BASE_HIGH: begin
                    base_high <= WDATA_I;
                end
                `WDCFG_IDX_BASE_LOW: begin
                    base_low <= WDATA_I & `WDCFG_BASE_LOW_MASK;
                end
                `WDCFG_IDX_IRQ_SELECT: begin
                    irq_select <= WDATA_I;
                end
                `WDCFG_IDX_IRQ_KIND: begin
                    irq_kind <= (irq_kind & ~`WDCFG_IRQ_KIND_WMASK)
                              | (WDATA_I & `WDCFG_IRQ_KIND_WMASK);
                end
                default: begin
                end
            endcase
        end
    end

    // Setup reset value and reserved bits
    always_ff @(posedge MCLK_I) begin
        if (!RSTN_I) begin
            setup <= `WDCFG_RST_SETUP;
        end else if (WR_I && ADDR_I == `WDCFG_IDX_SETUP) begin
            setup <= WDATA_I & `WDCFG_SETUP_WMASK;
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (!RSTN_I) begin
            RDATA_O <= 8'h00;
        end else if (RD_I) begin
            case (ADDR_I)
                `WDCFG_IDX_ACTIVATE:   RDATA_O <= activate;
                `WDCFG_IDX_BASE_HIGH:  RDATA_O <= base_high;
                `WDCFG_IDX_BASE_LOW:   RDATA_O <= base_low;
                `WDCFG_IDX_IRQ_SELECT: RDATA_O <= irq_select;
                `WDCFG_IDX_IRQ_KIND:   RDATA_O <= irq_kind;
                `WDCFG_IDX_DMA_A:      RDATA_O <= `WDCFG_VAL_NO_DMA;
                `WDCFG_IDX_DMA_B:      RDATA_O <= `WDCFG_VAL_NO_DMA;
                `WDCFG_IDX_SETUP:      RDATA_O <= setup;
                `WDCFG_IDX_EVT_STATUS: RDATA_O <= {5'h00, evt_status};
                `WDCFG_IDX_EVT_ENABLE: RDATA_O <= {5'h00, evt_enable};
                default:               RDATA_O <= 8'h00;
            endcase
        end else begin
            RDATA_O <= 8'h00;
        end
    end

    // Timeout and access strobe arrive from the counter core domain boundary
    always_ff @(posedge MCLK_I) begin
        if (!RSTN_I) begin
            to_meta  <= 1'b1;
            to_sync  <= 1'b1;
            to_prev  <= 1'b1;
            blk_meta <= 1'b0;
            blk_sync <= 1'b0;
        end else begin
            to_meta  <= TIMEOUT_N_I;
            to_sync  <= to_meta;
            to_prev  <= to_sync;
            blk_meta <= RT_ACCESS_I;
            blk_sync <= blk_meta;
        end
    end

    // Mode from activate and power bit
    always_comb begin
        if (!setup[`WDCFG_BIT_POWER_MODE]) begin
            mode = wdcfg_pkg::WDCFG_LOWPWR;
        end else if (active) begin
            mode = wdcfg_pkg::WDCFG_RUN;
        end else begin
            mode = wdcfg_pkg::WDCFG_OFF;
        end
    end

    always_comb begin
        next_pin.pullup_en    = setup[`WDCFG_BIT_PULLUP];
        next_pin.timer_clk_en = 1'b0;
        next_pin.out_value    = 1'b1;
        next_pin.out_enable   = 1'b0;
        case (mode)
            wdcfg_pkg::WDCFG_RUN: begin
                next_pin.timer_clk_en = 1'b1;
                next_pin.out_value    = to_sync;
            end
            wdcfg_pkg::WDCFG_LOWPWR: begin
                next_pin.timer_clk_en = 1'b0;
                next_pin.out_value    = 1'b1;
            end
            default: begin
                next_pin.timer_clk_en = 1'b0;
                next_pin.out_value    = 1'b1;
            end
        endcase
        // Push-pull drives both levels, open-drain only low
        next_pin.out_enable = setup[`WDCFG_BIT_PUSH_PULL] | ~next_pin.out_value;
        if (setup[`WDCFG_BIT_HIZ_CTRL] && !active) begin
            next_pin.out_enable = 1'b0;
        end
    end

    // Controls registered, effective one cycle after write
    always_ff @(posedge MCLK_I) begin
        if (!RSTN_I) begin
            pin <= '{timer_clk_en: 1'b0, pullup_en: 1'b0, out_value: 1'b1, out_enable: 1'b0};
        end else begin
            pin <= next_pin;
        end
    end

    assign TIMER_CLK_EN_O        = pin.timer_clk_en;
    assign TIMEOUT_PULLUP_O      = pin.pullup_en;
    assign TIMEOUT_OUTPUT_N_O    = pin.out_value;
    assign TIMEOUT_OUTPUT_N_OE_O = pin.out_enable;
    assign IRQ_SELECT_O          = irq_select;
    assign RT_ACCESS_OK_O        = active;

    assign wr_hit_act   = WR_I && ADDR_I == `WDCFG_IDX_ACTIVATE;
    assign wr_hit_setup = WR_I && ADDR_I == `WDCFG_IDX_SETUP;

    always_comb begin
        evt_set                     = 3'h0;
        evt_set[`WDCFG_EVT_EXPIRY]  = to_prev & ~to_sync & (mode == wdcfg_pkg::WDCFG_RUN);
        evt_set[`WDCFG_EVT_LOW_POWER] = wr_hit_setup & setup[`WDCFG_BIT_POWER_MODE]
                                      & ~WDATA_I[`WDCFG_BIT_POWER_MODE];
        evt_set[`WDCFG_EVT_BLOCKED] = blk_sync & ~active;
    end

    // Sticky events; a set in the clear cycle survives
    always_ff @(posedge MCLK_I) begin
        if (!RSTN_I) begin
            evt_status <= 3'h0;
        end else if (WR_I && ADDR_I == `WDCFG_IDX_EVT_CLEAR) begin
            evt_status <= (evt_status & ~WDATA_I[2:0]) | evt_set;
        end else begin
            evt_status <= evt_status | evt_set;
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (!RSTN_I) begin
            evt_enable <= 3'h0;
        end else if (WR_I && ADDR_I == `WDCFG_IDX_EVT_ENABLE) begin
            evt_enable <= WDATA_I[2:0];
        end
    end

    assign IRQ_O = |(evt_status & evt_enable);

    chk_lowpwr_clk_off: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
        !setup[`WDCFG_BIT_POWER_MODE] |=> !TIMER_CLK_EN_O)
        else $error("timer clock runs in low power mode");
    chk_lowpwr_out_high: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
        !setup[`WDCFG_BIT_POWER_MODE] |=> TIMEOUT_OUTPUT_N_O)
        else $error("timeout output not inactive in low power");
    chk_run_needs_act: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
        TIMER_CLK_EN_O |-> $past(active) && $past(setup[`WDCFG_BIT_POWER_MODE]))
        else $error("timer runs while not activated");
    chk_hiz_inactive: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
        ($past(setup[`WDCFG_BIT_HIZ_CTRL]) && !$past(active)) |-> !TIMEOUT_OUTPUT_N_OE_O)
        else $error("pin driven while tristated");
    chk_open_drain: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
        (TIMEOUT_OUTPUT_N_OE_O && TIMEOUT_OUTPUT_N_O) |-> $past(setup[`WDCFG_BIT_PUSH_PULL]))
        else $error("open-drain pin drives high");
    chk_base_align: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
        base_low[1:0] == 2'b00)
        else $error("base low bits not zero");
    chk_kind_fixed: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
        (irq_kind & ~`WDCFG_IRQ_KIND_WMASK) == (`WDCFG_RST_IRQ_KIND & ~`WDCFG_IRQ_KIND_WMASK))
        else $error("read-only interrupt kind bits changed");
    chk_dma_report: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
        RD_I && (ADDR_I == `WDCFG_IDX_DMA_A || ADDR_I == `WDCFG_IDX_DMA_B)
        |=> RDATA_O == `WDCFG_VAL_NO_DMA)
        else $error("DMA report not 04h");
    chk_setup_apply: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
        wr_hit_setup ##1 1'b1 |=> TIMEOUT_PULLUP_O == $past(WDATA_I[`WDCFG_BIT_PULLUP], 2))
        else $error("pull-up not applied after write");
    chk_access_gate: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
        wr_hit_act |=> RT_ACCESS_OK_O == $past(WDATA_I[0]))
        else $error("runtime access gate wrong");
    chk_setup_rsvd: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
        setup[7:4] == 4'h0)
        else $error("reserved setup bits set");

    chk_gate_level: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
        RT_ACCESS_OK_O == activate[`WDCFG_BIT_ACT_ENABLE])
        else $error("runtime gate differs from activate bit");

    chk_act_write: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
        wr_hit_act |=> activate == $past(WDATA_I))
        else $error("activate write lost");

    chk_act_read: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
        RD_I && ADDR_I == `WDCFG_IDX_ACTIVATE |=> RDATA_O == $past(activate))
        else $error("activate read wrong");

    chk_base_high_wr: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
        WR_I && ADDR_I == `WDCFG_IDX_BASE_HIGH |=> base_high == $past(WDATA_I))
        else $error("base high write lost");

    chk_base_high_rd: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
        RD_I && ADDR_I == `WDCFG_IDX_BASE_HIGH |=> RDATA_O == $past(base_high))
        else $error("base high read wrong");

    chk_base_low_wr: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
        WR_I && ADDR_I == `WDCFG_IDX_BASE_LOW
        |=> base_low == ($past(WDATA_I) & `WDCFG_BASE_LOW_MASK))
        else $error("base low write wrong");

    chk_base_low_rd: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
        RD_I && ADDR_I == `WDCFG_IDX_BASE_LOW |=> RDATA_O[1:0] == 2'b00)
        else $error("base low bits read nonzero");

    chk_irq_sel_out: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
        IRQ_SELECT_O == irq_select)
        else $error("interrupt select output differs");

    chk_irq_sel_wr: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
        WR_I && ADDR_I == `WDCFG_IDX_IRQ_SELECT |=> irq_select == $past(WDATA_I))
        else $error("interrupt select write lost");

    chk_kind_bit1: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
        WR_I && ADDR_I == `WDCFG_IDX_IRQ_KIND |=> irq_kind[1] == $past(WDATA_I[1]))
        else $error("interrupt kind bit 1 not written");

    chk_kind_read: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
        RD_I && ADDR_I == `WDCFG_IDX_IRQ_KIND |=> RDATA_O == $past(irq_kind))
        else $error("interrupt kind read wrong");

    chk_setup_write: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
        wr_hit_setup |=> setup == ($past(WDATA_I) & `WDCFG_SETUP_WMASK))
        else $error("setup write wrong");

    chk_setup_rsvd_rd: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
        RD_I && ADDR_I == `WDCFG_IDX_SETUP |=> RDATA_O[7:4] == 4'h0)
        else $error("reserved setup bits read nonzero");

    chk_push_pull_oe: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
        $past(setup[`WDCFG_BIT_PUSH_PULL]) && $past(active) |-> TIMEOUT_OUTPUT_N_OE_O)
        else $error("push-pull pin not driven");

    chk_low_drives: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
        !TIMEOUT_OUTPUT_N_O |-> TIMEOUT_OUTPUT_N_OE_O)
        else $error("timeout low not driven");

    chk_pullup_follow: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
        TIMEOUT_PULLUP_O == $past(setup[`WDCFG_BIT_PULLUP]))
        else $error("pull-up control differs from setup");

    chk_lowpwr_quiet: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
        !setup[`WDCFG_BIT_POWER_MODE] |-> !evt_set[`WDCFG_EVT_EXPIRY])
        else $error("expiry seen in low power mode");

    chk_setup_read: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
        RD_I && ADDR_I == `WDCFG_IDX_SETUP |=> RDATA_O == $past(setup))
        else $error("setup read wrong");

    chk_lowpwr_keep: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
        !setup[`WDCFG_BIT_POWER_MODE] && !WR_I |=> $stable(base_high) && $stable(irq_select))
        else $error("register changed in low power mode");

    chk_clk_en_exact: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
        TIMER_CLK_EN_O == ($past(active) && $past(setup[`WDCFG_BIT_POWER_MODE])))
        else $error("timer clock enable wrong");

    chk_out_follows: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
        TIMER_CLK_EN_O |-> TIMEOUT_OUTPUT_N_O == $past(to_sync))
        else $error("timeout pin does not follow timeout");

    chk_setup_gate: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
        wr_hit_setup ##1 1'b1
        |=> TIMER_CLK_EN_O == ($past(WDATA_I[`WDCFG_BIT_POWER_MODE], 2) && $past(active)))
        else $error("clock gate not applied after write");
endmodule
`default_nettype wire

// file: test/wdcfg_bank_test.sv
// Self-checking bench of the timer configuration bank
`timescale 1ns/1ns
`default_nettype none
`include "wdcfg_regs.svh"
module wdcfg_bank_test;
    logic       MCLK_I = 1'b0;
    logic       RSTN_I = 1'b0;
    logic [7:0] ADDR_I = 8'h00;
    logic [7:0] WDATA_I = 8'h00;
    logic       WR_I = 1'b0;
    logic       RD_I = 1'b0;
    logic       TIMEOUT_N_I = 1'b1;
    logic       RT_ACCESS_I = 1'b0;
    logic [7:0] RDATA_O;
    logic       RT_ACCESS_OK_O;
    logic       TIMER_CLK_EN_O;
    logic       TIMEOUT_OUTPUT_N_O;
    logic       TIMEOUT_OUTPUT_N_OE_O;
    logic       TIMEOUT_PULLUP_O;
    logic [7:0] IRQ_SELECT_O;
    logic       IRQ_O;
    int         n_mismatch = 0;
    int         samples_checked = 0;

    always #50 MCLK_I = ~MCLK_I;

    wdcfg_bank i_dut (.MCLK_I(MCLK_I), .RSTN_I(RSTN_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
        .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .TIMEOUT_N_I(TIMEOUT_N_I),
        .RT_ACCESS_I(RT_ACCESS_I), .RT_ACCESS_OK_O(RT_ACCESS_OK_O),
        .TIMER_CLK_EN_O(TIMER_CLK_EN_O), .TIMEOUT_OUTPUT_N_O(TIMEOUT_OUTPUT_N_O),
        .TIMEOUT_OUTPUT_N_OE_O(TIMEOUT_OUTPUT_N_OE_O), .TIMEOUT_PULLUP_O(TIMEOUT_PULLUP_O),
        .IRQ_SELECT_O(IRQ_SELECT_O), .IRQ_O(IRQ_O));

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge MCLK_I);
        ADDR_I <= a;
        WDATA_I <= d;
        WR_I <= 1'b1;
        @(posedge MCLK_I);
        WR_I <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge MCLK_I);
        ADDR_I <= a;
        RD_I <= 1'b1;
        @(posedge MCLK_I);
        RD_I <= 1'b0;
        #10;
        chk(RDATA_O, e);
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge MCLK_I);
        #10;
    endtask

    task automatic drive_pins(input logic tmo_n, input logic rt);
        @(posedge MCLK_I);
        TIMEOUT_N_I <= tmo_n;
        RT_ACCESS_I <= rt;
    endtask

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Hang guard, far beyond the length of the main sequence
    initial begin
        #2000000;
        n_mismatch++;
        $display("BAD %0t run did not finish", $time);
        report_and_stop();
    end

    initial begin
        repeat (6) @(posedge MCLK_I);
        RSTN_I <= 1'b1;
        rd(8'h30, 8'h00);
        rd(8'h60, 8'h00);
        rd(8'h61, 8'h00);
        rd(8'h70, 8'h00);
        rd(8'h71, 8'h03);
        rd(8'h74, 8'h04);
        rd(8'h75, 8'h04);
        rd(8'hF0, 8'h02);
        chk(RT_ACCESS_OK_O, 8'h00);
        chk(TIMER_CLK_EN_O, 8'h00);
        chk(TIMEOUT_PULLUP_O, 8'h00);
        $display("test reset values done");
        wr(8'h60, 8'hA5);
        wr(8'h61, 8'hFF);
        wr(8'h70, 8'h5B);
        wr(8'h71, 8'h00);
        wr(8'h74, 8'h00);
        wr(8'h75, 8'hFF);
        wr(8'h40, 8'h77);
        rd(8'h60, 8'hA5);
        rd(8'h61, 8'hFC);
        rd(8'h70, 8'h5B);
        chk(IRQ_SELECT_O, 8'h5B);
        rd(8'h71, 8'h01);
        rd(8'h74, 8'h04);
        rd(8'h75, 8'h04);
        rd(8'h40, 8'h00);
        step(1);
        chk(RDATA_O, 8'h00);
        wr(8'h71, 8'hFF);
        rd(8'h71, 8'h03);
        wr(8'hF0, 8'hF2);
        rd(8'hF0, 8'h02);
        $display("test register access done");
        wr(8'h30, 8'h01);
        step(1);
        chk(RT_ACCESS_OK_O, 8'h01);
        chk(TIMER_CLK_EN_O, 8'h01);
        chk(TIMEOUT_OUTPUT_N_OE_O, 8'h00);
        wr(`WDCFG_IDX_EVT_CLEAR, 8'h07);
        drive_pins(1'b0, 1'b0);
        step(4);
        chk(TIMEOUT_OUTPUT_N_O, 8'h00);
        chk(TIMEOUT_OUTPUT_N_OE_O, 8'h01);
        rd(`WDCFG_IDX_EVT_STATUS, 8'h01);
        chk(IRQ_O, 8'h00);
        wr(`WDCFG_IDX_EVT_ENABLE, 8'h01);
        step(1);
        chk(IRQ_O, 8'h01);
        wr(`WDCFG_IDX_EVT_CLEAR, 8'h01);
        step(1);
        chk(IRQ_O, 8'h00);
        rd(`WDCFG_IDX_EVT_CLEAR, 8'h00);
        wr(8'hF0, 8'h0E);
        step(1);
        chk(TIMEOUT_PULLUP_O, 8'h01);
        drive_pins(1'b1, 1'b0);
        step(4);
        chk(TIMEOUT_OUTPUT_N_O, 8'h01);
        chk(TIMEOUT_OUTPUT_N_OE_O, 8'h01);
        $display("test run mode done");
        wr(`WDCFG_IDX_EVT_ENABLE, 8'h02);
        wr(8'hF0, 8'h0C);
        step(1);
        chk(TIMER_CLK_EN_O, 8'h00);
        chk(IRQ_O, 8'h01);
        drive_pins(1'b0, 1'b0);
        step(4);
        chk(TIMEOUT_OUTPUT_N_O, 8'h01);
        rd(8'h60, 8'hA5);
        rd(8'hF0, 8'h0C);
        rd(`WDCFG_IDX_EVT_STATUS, 8'h02);
        wr(`WDCFG_IDX_EVT_CLEAR, 8'h02);
        wr(`WDCFG_IDX_EVT_ENABLE, 8'h00);
        drive_pins(1'b1, 1'b0);
        $display("test low power done");
        wr(8'h30, 8'h00);
        wr(8'hF0, 8'h0B);
        step(1);
        chk(RT_ACCESS_OK_O, 8'h00);
        chk(TIMER_CLK_EN_O, 8'h00);
        chk(TIMEOUT_OUTPUT_N_OE_O, 8'h00);
        wr(8'hF0, 8'h0A);
        step(1);
        chk(TIMEOUT_OUTPUT_N_OE_O, 8'h01);
        drive_pins(1'b1, 1'b1);
        step(4);
        drive_pins(1'b1, 1'b0);
        step(4);
        rd(`WDCFG_IDX_EVT_STATUS, 8'h04);
        wr(`WDCFG_IDX_EVT_ENABLE, 8'h04);
        step(1);
        chk(IRQ_O, 8'h01);
        wr(`WDCFG_IDX_EVT_CLEAR, 8'h04);
        step(1);
        chk(IRQ_O, 8'h00);
        $display("test inactive outputs done");
        report_and_stop();
    end
endmodule
`default_nettype wire
